// file: src/cies_pkg.sv
/*
  Constants, types and field layouts for the instruction execute subset.
  Assumes one 20 MHz core clock, an outside fetch unit, file register array and return stack.
*/
package cies_pkg;

  // ---------------------------------------------------------------
  // Opcode fields
  // ---------------------------------------------------------------
  localparam logic [1:0]  OPG_BYTE      = 2'h0;
  localparam logic [1:0]  OPG_BIT       = 2'h1;
  localparam logic [1:0]  OPG_CTRL      = 2'h2;
  localparam logic [1:0]  OPG_LIT       = 2'h3;
  localparam logic [3:0]  SUB_WTOF      = 4'h0;
  localparam logic [3:0]  SUB_CLR       = 4'h1;
  localparam logic [3:0]  SUB_DEC       = 4'h3;
  localparam logic [3:0]  SUB_ORF       = 4'h4;
  localparam logic [3:0]  SUB_MOVEF     = 4'h8;
  localparam logic [3:0]  SUB_CPL       = 4'h9;
  localparam logic [3:0]  SUB_INC       = 4'hA;
  localparam logic [3:0]  SUB_DECSZ     = 4'hB;
  localparam logic [3:0]  SUB_INCSZ     = 4'hF;
  localparam logic [3:0]  SUB_ORLIT     = 4'h8;
  localparam logic [1:0]  BSUB_SET      = 2'h1;
  localparam logic [1:0]  BSUB_TSTSET   = 2'h3;
  localparam logic [1:0]  LSUB_LDLIT    = 2'h0;
  localparam logic [13:0] WDOG_CLR_WORD = 14'h0064;

  // ---------------------------------------------------------------
  // Register port map and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_LATCH     = 8'h04;
  localparam logic [7:0]  OFS_STATUS    = 8'h08;
  localparam logic [7:0]  OFS_WDOG      = 8'h0C;
  localparam int          ST_Z_BIT      = 8;
  localparam int          ST_TO_BIT     = 9;
  localparam int          ST_PWDN_BIT   = 10;
  localparam logic        RST_ENABLE    = 1'h1;
  localparam logic [4:0]  RST_LATCH     = 5'h00;
  localparam logic [7:0]  RST_W         = 8'h00;
  localparam logic        RST_STATUS1   = 1'h1;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_IDLE     = 5'b00000, OP_BITSET  = 5'b00001, OP_BITTST = 5'b00010, OP_CLRFILE = 5'b00011,
    OP_CLRWORK  = 5'b00100, OP_WDTC    = 5'b00101, OP_CPL    = 5'b00110, OP_DEC     = 5'b00111,
    OP_DECSZ    = 5'b01000, OP_INC     = 5'b01001, OP_INCSZ  = 5'b01010, OP_ORFILE  = 5'b01011,
    OP_MOVEFILE = 5'b01100, OP_WTOF    = 5'b01101, OP_ORLIT  = 5'b01110, OP_LDLIT   = 5'b01111,
    OP_CALL     = 5'b10000, OP_BRANCH  = 5'b10001
  } cies_op_t;

  typedef enum logic {
    ST_EXEC   = 1'b0,
    ST_SQUASH = 1'b1
  } cies_state_t;

  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] data;
  } cies_fwr_t;

  typedef struct packed {
    logic        load;
    logic        push;
    logic [12:0] target;
    logic [12:0] ret_addr;
  } cies_pcc_t;

endpackage

// file: src/cies_exec.sv
/*
  Execute stage for a subset of the 14-bit instruction set: file ops, bit ops,
  literal ops, call, branch and watchdog clear, plus a small register port.
  Assumes the fetch unit presents one instruction per cycle with its address,
  the file array answers file_rdata combinationally for file_raddr, and the
  stack and pc follow pc_ctrl one cycle after execution.
*/
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
module cies_exec (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              instr_valid,
  input  wire logic [13:0]       instr_word,
  input  wire logic [12:0]       pc_cur,
  output logic                   instr_discard,
  output logic      [6:0]        file_raddr,
  input  wire logic [7:0]        file_rdata,
  output cies_pkg::cies_fwr_t    file_wr,
  output cies_pkg::cies_pcc_t    pc_ctrl,
  output logic      [7:0]        working_reg,
  output logic                   zero_flag,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata
);
  import cies_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  cies_state_t  state_ff, nxt_state;
  cies_fwr_t    fwr_ff, nxt_fwr;
  cies_pcc_t    pcc_ff, nxt_pcc;
  logic [7:0]   w_ff, nxt_w;
  logic         z_ff, nxt_z;
  logic         to_ff, nxt_to;
  logic         pd_ff, nxt_pd;
  logic         enable_ff;
  logic [4:0]   latch_ff;
  logic [7:0]   wdt_cnt_ff, nxt_wdt_cnt;
  logic [7:0]   wdt_pre_ff, nxt_wdt_pre;
  logic [31:0]  rdata_ff, nxt_rdata;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire [1:0]  grp       = instr_word[13:12];
  wire [3:0]  sub       = instr_word[11:8];
  wire        dbit      = instr_word[7];
  wire [2:0]  bsel      = instr_word[9:7];
  wire [7:0]  lit       = instr_word[7:0];
  wire [7:0]  bmask     = 8'h01 << bsel;
  wire        squashing = (state_ff == ST_SQUASH);
  wire        exec      = instr_valid && enable_ff && !squashing;
  cies_op_t   op;

  always_comb begin
    op = OP_IDLE;
    case (grp)
      OPG_BYTE: begin
        case (sub)
          SUB_WTOF:  op = dbit ? OP_WTOF : ((instr_word == WDOG_CLR_WORD) ? OP_WDTC : OP_IDLE);
          SUB_CLR:   op = dbit ? OP_CLRFILE : OP_CLRWORK;
          SUB_CPL:   op = OP_CPL;
          SUB_DEC:   op = OP_DEC;
          SUB_DECSZ: op = OP_DECSZ;
          SUB_INC:   op = OP_INC;
          SUB_INCSZ: op = OP_INCSZ;
          SUB_ORF:   op = OP_ORFILE;
          SUB_MOVEF: op = OP_MOVEFILE;
          default:   op = OP_IDLE;
        endcase
      end
      OPG_BIT: begin
        if (instr_word[11:10] == BSUB_SET) begin
          op = OP_BITSET;
        end else if (instr_word[11:10] == BSUB_TSTSET) begin
          op = OP_BITTST;
        end
      end
      OPG_CTRL: op = instr_word[11] ? OP_BRANCH : OP_CALL;
      OPG_LIT: begin
        if (sub == SUB_ORLIT) begin
          op = OP_ORLIT;
        end else if (instr_word[11:10] == LSUB_LDLIT) begin
          op = OP_LDLIT;
        end
      end
      default: op = OP_IDLE;
    endcase
  end

  // Forward the pending write so back-to-back ops on one file see fresh data
  assign file_raddr = instr_word[6:0];
  wire        fwd      = fwr_ff.we && (fwr_ff.addr == file_raddr);
  wire [7:0]  f_val    = fwd ? fwr_ff.data : file_rdata;
  wire [7:0]  f_inc    = f_val + 8'h01;
  wire [7:0]  f_dec    = f_val - 8'h01;
  wire        byte_dst = (op == OP_CPL) || (op == OP_DEC) || (op == OP_DECSZ) || (op == OP_INC) ||
                         (op == OP_INCSZ) || (op == OP_ORFILE) || (op == OP_MOVEFILE);
  wire [12:0] br_tgt   = {latch_ff[4:3], instr_word[10:0]};

  // ---------------------------------------------------------------
  // Execute
  // ---------------------------------------------------------------
  logic [7:0] res;
  logic       upd_z;
  logic       skip;
  logic       wdt_clr;

  always_comb begin
    res     = f_val;
    upd_z   = 1'b0;
    skip    = 1'b0;
    wdt_clr = 1'b0;
    nxt_fwr = '{we: 1'b0, addr: file_raddr, data: 8'h00};
    nxt_pcc = '{load: 1'b0, push: 1'b0, target: br_tgt, ret_addr: pc_cur + 13'h0001};
    nxt_w   = w_ff;
    if (exec) begin
      case (op)
        OP_BITSET:   res = f_val | bmask;
        OP_BITTST:   skip = |(f_val & bmask);
        OP_CLRFILE:  begin res = 8'h00; upd_z = 1'b1; end
        OP_CLRWORK:  begin res = 8'h00; upd_z = 1'b1; end
        OP_WDTC:     wdt_clr = 1'b1;
        OP_CPL:      begin res = ~f_val; upd_z = 1'b1; end
        OP_DEC:      begin res = f_dec; upd_z = 1'b1; end
        OP_INC:      begin res = f_inc; upd_z = 1'b1; end
        OP_DECSZ:    begin res = f_dec; skip = (f_dec == 8'h00); end
        OP_INCSZ:    begin res = f_inc; skip = (f_inc == 8'h00); end
        OP_ORFILE:   begin res = w_ff | f_val; upd_z = 1'b1; end
        OP_MOVEFILE: upd_z = 1'b1;
        OP_WTOF:     res = w_ff;
        OP_ORLIT:    begin res = w_ff | lit; upd_z = 1'b1; end
        OP_LDLIT:    res = lit;
        OP_CALL:     begin nxt_pcc.load = 1'b1; nxt_pcc.push = 1'b1; end
        OP_BRANCH:   nxt_pcc.load = 1'b1;
        default:     res = f_val;
      endcase
      // Destination routing
      if ((op == OP_BITSET) || (op == OP_CLRFILE) || (op == OP_WTOF) || (byte_dst && dbit)) begin
        nxt_fwr.we = 1'b1;
      end
      nxt_fwr.data = res;
      if ((op == OP_CLRWORK) || (op == OP_ORLIT) || (op == OP_LDLIT) || (byte_dst && !dbit)) begin
        nxt_w = res;
      end
    end
  end

  assign nxt_z = upd_z ? (res == 8'h00) : z_ff;

  // Skip or branch squashes the already fetched word
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_EXEC:   if (skip || nxt_pcc.load) nxt_state = ST_SQUASH;
      ST_SQUASH: if (instr_valid) nxt_state = ST_EXEC;
      default:   nxt_state = ST_EXEC;
    endcase
  end

  assign instr_discard = squashing && instr_valid;

  // ---------------------------------------------------------------
  // Watchdog and status bits
  // ---------------------------------------------------------------
  // Prescaler wraps into the counter; clear beats any tick
  assign nxt_wdt_pre = wdt_clr ? 8'h00 : wdt_pre_ff + 8'h01;
  assign nxt_wdt_cnt = wdt_clr ? 8'h00 : ((wdt_pre_ff == 8'hFF) ? wdt_cnt_ff + 8'h01 : wdt_cnt_ff);

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  wire wr_ctrl   = reg_wr && (reg_addr == OFS_CTRL);
  wire wr_latch  = reg_wr && (reg_addr == OFS_LATCH);
  wire wr_status = reg_wr && (reg_addr == OFS_STATUS);
  wire [31:0] status_word = {21'h0, pd_ff, to_ff, z_ff, w_ff};

  // Hardware set wins over a software clear in the same cycle
  assign nxt_to = wdt_clr | (wr_status ? reg_wdata[ST_TO_BIT] : to_ff);
  assign nxt_pd = wdt_clr | (wr_status ? reg_wdata[ST_PWDN_BIT] : pd_ff);

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL:   nxt_rdata = {31'h0, enable_ff};
        OFS_LATCH:  nxt_rdata = {27'h0, latch_ff};
        OFS_STATUS: nxt_rdata = status_word;
        OFS_WDOG:   nxt_rdata = {16'h0, wdt_pre_ff, wdt_cnt_ff};
        default:    nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Flip-flops
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff   <= ST_EXEC;
      fwr_ff     <= '0;
      pcc_ff     <= '0;
      w_ff       <= RST_W;
      z_ff       <= 1'b0;
      to_ff      <= RST_STATUS1;
      pd_ff      <= RST_STATUS1;
      wdt_cnt_ff <= 8'h00;
      wdt_pre_ff <= 8'h00;
      rdata_ff   <= 32'h0000_0000;
    end else begin
      state_ff   <= nxt_state;
      fwr_ff     <= nxt_fwr;
      pcc_ff     <= nxt_pcc;
      w_ff       <= nxt_w;
      z_ff       <= nxt_z;
      to_ff      <= nxt_to;
      pd_ff      <= nxt_pd;
      wdt_cnt_ff <= nxt_wdt_cnt;
      wdt_pre_ff <= nxt_wdt_pre;
      rdata_ff   <= nxt_rdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_ff <= RST_ENABLE;
      latch_ff  <= RST_LATCH;
    end else begin
      if (wr_ctrl) enable_ff <= reg_wdata[0];
      if (wr_latch) latch_ff <= reg_wdata[4:0];
    end
  end

  assign file_wr     = fwr_ff;
  assign pc_ctrl     = pcc_ff;
  assign working_reg = w_ff;
  assign zero_flag   = z_ff;
  assign reg_rdata   = rdata_ff;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Result of the last cycle, so the flag check reads a plain register
  logic [7:0] res_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      res_q <= 8'h00;
    end else begin
      res_q <= res;
    end
  end

  wire go_set = exec && (op == OP_BITSET);
  wire go_bts = exec && (op == OP_BITTST);
  wire go_hit = go_bts && ((f_val & bmask) != 8'h00);

  property p_bitset;
    go_set |=> fwr_ff.we && fwr_ff.data == ($past(f_val) | $past(bmask)) && $stable(z_ff);
  endproperty
  a_bitset: assert property (p_bitset) else $error("bit set result wrong");

  property p_bittst;
    go_hit |=> squashing && (!instr_valid || instr_discard);
  endproperty
  a_bittst: assert property (p_bittst) else $error("bit test skip missing");

  property p_bittst_no;
    go_bts && !go_hit |=> !squashing;
  endproperty
  a_bittst_no: assert property (p_bittst_no) else $error("bit test skipped wrongly");

  property p_clrfile;
    exec && op == OP_CLRFILE |=> fwr_ff.we && fwr_ff.data == 8'h00 && z_ff;
  endproperty
  a_clrfile: assert property (p_clrfile) else $error("clear file wrong");

  property p_call;
    exec && op == OP_CALL |=> pcc_ff.load && pcc_ff.push && pcc_ff.ret_addr == $past(pc_cur) + 13'h0001 &&
      pcc_ff.target == {$past(latch_ff[4:3]), $past(instr_word[10:0])};
  endproperty
  a_call: assert property (p_call) else $error("call wrong");

  property p_clrwork;
    exec && op == OP_CLRWORK |=> w_ff == 8'h00 && z_ff && !fwr_ff.we;
  endproperty
  a_clrwork: assert property (p_clrwork) else $error("clear working wrong");

  property p_wdtc;
    exec && op == OP_WDTC |=> wdt_cnt_ff == 8'h00 && wdt_pre_ff == 8'h00 && to_ff && pd_ff;
  endproperty
  a_wdtc: assert property (p_wdtc) else $error("watchdog clear wrong");

  property p_dest;
    exec && byte_dst |=> fwr_ff.we == $past(dbit) && (fwr_ff.we || w_ff == fwr_ff.data);
  endproperty
  a_dest: assert property (p_dest) else $error("destination routing wrong");

  property p_cpl;
    exec && op == OP_CPL |=> fwr_ff.data == ~$past(f_val) && z_ff == (fwr_ff.data == 8'h00);
  endproperty
  a_cpl: assert property (p_cpl) else $error("complement wrong");

  property p_decsz;
    exec && op == OP_DECSZ |=> $stable(z_ff) && squashing == ($past(f_val) == 8'h01);
  endproperty
  a_decsz: assert property (p_decsz) else $error("decrement skip wrong");

  property p_incsz;
    exec && op == OP_INCSZ |=> $stable(z_ff) && squashing == ($past(f_val) == 8'hFF);
  endproperty
  a_incsz: assert property (p_incsz) else $error("increment skip wrong");

  // Second cycle of a branch is the squashed slot: no new load there
  property p_branch;
    exec && op == OP_BRANCH |=> pcc_ff.load && !pcc_ff.push &&
      pcc_ff.target == {$past(latch_ff[4:3]), $past(instr_word[10:0])} ##1 !pcc_ff.load;
  endproperty
  a_branch: assert property (p_branch) else $error("branch wrong");

  property p_orlit;
    exec && op == OP_ORLIT |=> w_ff == ($past(w_ff) | $past(lit)) && z_ff == (w_ff == 8'h00);
  endproperty
  a_orlit: assert property (p_orlit) else $error("or literal wrong");

  property p_wtof;
    exec && op == OP_WTOF |=> fwr_ff.we && fwr_ff.data == $past(w_ff) && $stable(z_ff);
  endproperty
  a_wtof: assert property (p_wtof) else $error("move to file wrong");

  property p_incdec;
    exec && (op == OP_INC || op == OP_DEC) |=> z_ff == (res_q == 8'h00) && !squashing;
  endproperty
  a_incdec: assert property (p_incdec) else $error("increment or decrement flag wrong");

  property p_ldlit;
    exec && op == OP_LDLIT |=> w_ff == $past(lit) && $stable(z_ff);
  endproperty
  a_ldlit: assert property (p_ldlit) else $error("move literal wrong");

  // Disabled core must leave every architectural output alone
  property p_halted;
    instr_valid && !enable_ff |=> !fwr_ff.we && !pcc_ff.load && $stable(w_ff) && $stable(z_ff);
  endproperty
  a_halted: assert property (p_halted) else $error("disabled core still executed");

  property p_rdata_idle;
    !reg_rd |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");

  property p_cv_call;
    exec && op == OP_CALL ##1 instr_discard;
  endproperty
  c_cv_call: cover property (p_cv_call);

  property p_cv_skip;
    go_hit ##1 squashing;
  endproperty
  c_cv_skip: cover property (p_cv_skip);

  property p_cv_wdt;
    exec && op == OP_WDTC ##1 to_ff && pd_ff;
  endproperty
  c_cv_wdt: cover property (p_cv_wdt);

  property p_cv_branch;
    exec && op == OP_BRANCH ##1 instr_discard;
  endproperty
  c_cv_branch: cover property (p_cv_branch);

endmodule // cies_exec

// file: tb/testbench.sv
/*
  Self-checking bench for the instruction execute subset: table of file, bit and literal ops,
  then skips, call, branch, watchdog clear and the register port.
  Assumes cies_pkg and cies_exec are compiled first; the bench stands in for the file array.
*/
`timescale 1ns/1ps
module testbench;
  import cies_pkg::*;

  typedef struct packed {
    logic [13:0] word;
    logic [7:0]  wpre;
    logic [7:0]  fval;
    logic        we;
    logic [7:0]  fdata;
    logic [7:0]  w;
    logic        z;
  } cies_row_t;

  localparam logic [6:0]  FA   = 7'h21;
  localparam logic [13:0] CLR_WORKING = {OPG_BYTE, SUB_CLR, 8'h00};
  localparam logic [13:0] LDC3 = {OPG_LIT, LSUB_LDLIT, 2'b00, 8'hC3};
  localparam logic [12:0] PC0  = 13'h0123;

  logic        core_clk, rst_n, instr_valid, instr_discard, reg_wr, reg_rd, zero_flag, disc;
  logic [13:0] instr_word;
  logic [12:0] pc_cur;
  logic [6:0]  file_raddr;
  logic [7:0]  file_rdata, working_reg, reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd;
  cies_fwr_t   file_wr, snap_fwr;
  cies_pcc_t   pc_ctrl, snap_pcc;
  logic [7:0]  fmem [128];
  cies_row_t   rows [19];
  int          num_errors, tests_run, cycles;

  cies_exec cies_exec_inst (.core_clk(core_clk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .pc_cur(pc_cur), .instr_discard(instr_discard), .file_raddr(file_raddr),
    .file_rdata(file_rdata), .file_wr(file_wr), .pc_ctrl(pc_ctrl), .working_reg(working_reg),
    .zero_flag(zero_flag), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // -------------------------------------------------------------
  // Clock, file array, hang guard
  // -------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Combinational answer, as the execute stage expects it in the same cycle
  assign file_rdata = fmem[file_raddr];

  always @(posedge core_clk) begin
    if (file_wr.we) fmem[file_wr.addr] <= file_wr.data;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      complete_run();
    end
  end

  // -------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic exec(input logic [13:0] w);
    @(posedge core_clk);
    instr_valid <= 1'b1;
    instr_word  <= w;
    pc_cur      <= PC0;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    #1;
  endtask

  // Two words back to back; the second is the one a skip must throw away
  task automatic run2(input logic [13:0] w1);
    @(posedge core_clk);
    instr_valid <= 1'b1;
    instr_word  <= w1;
    pc_cur      <= PC0;
    @(posedge core_clk);
    instr_word  <= LDC3;
    pc_cur      <= PC0 + 13'h0001;
    #1;
    snap_fwr = file_wr;
    snap_pcc = pc_ctrl;
    disc     = instr_discard;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    #1;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask

  // Clear then or-in gives a known working value and zero flag
  task automatic preset_w(input logic [7:0] v);
    exec(CLR_WORKING);
    exec({OPG_LIT, SUB_ORLIT, v});
  endtask

  task automatic skip_case(input logic [13:0] w1, input logic [7:0] fv, input logic d, input logic [8:0] fexp);
    preset_w(8'h11);
    fmem[FA] = fv;
    run2(w1);
    chk(32'(disc), 32'(d));
    chk(32'(working_reg), d ? 32'h0000_0011 : 32'h0000_00C3);
    if (fexp[8]) chk(32'({snap_fwr.we, snap_fwr.data}), 32'({1'b1, fexp[7:0]}));
  endtask

  task automatic complete_run();
    $display("TB: checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    instr_valid = 1'b0;
    instr_word = 14'h0000;
    pc_cur = 13'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    num_errors = 0;
    tests_run = 0;
    cycles = 0;
    foreach (fmem[i]) fmem[i] = 8'h00;
    rows = '{
      '{{OPG_BIT, BSUB_SET, 3'd7, FA},       8'h00, 8'h0A, 1'b1, 8'h8A, 8'h00, 1'b1},
      '{{OPG_BYTE, SUB_CLR, 1'b1, FA},       8'h33, 8'h5A, 1'b1, 8'h00, 8'h33, 1'b1},
      '{{OPG_BYTE, SUB_CLR, 1'b0, 7'h55},    8'h5A, 8'h77, 1'b0, 8'h00, 8'h00, 1'b1},
      '{{OPG_BYTE, SUB_CPL, 1'b0, FA},       8'h00, 8'h13, 1'b0, 8'h00, 8'hEC, 1'b0},
      '{{OPG_BYTE, SUB_CPL, 1'b1, FA},       8'h12, 8'hFF, 1'b1, 8'h00, 8'h12, 1'b1},
      '{{OPG_BYTE, SUB_DEC, 1'b1, FA},       8'h44, 8'h01, 1'b1, 8'h00, 8'h44, 1'b1},
      '{{OPG_BYTE, SUB_INC, 1'b0, FA},       8'h44, 8'hFF, 1'b0, 8'h00, 8'h00, 1'b1},
      '{{OPG_BYTE, SUB_INC, 1'b1, FA},       8'h00, 8'h7F, 1'b1, 8'h80, 8'h00, 1'b0},
      '{{OPG_BYTE, SUB_DEC, 1'b0, FA},       8'h00, 8'h00, 1'b0, 8'h00, 8'hFF, 1'b0},
      '{{OPG_BYTE, SUB_DECSZ, 1'b1, FA},     8'h00, 8'h05, 1'b1, 8'h04, 8'h00, 1'b1},
      '{{OPG_BYTE, SUB_INCSZ, 1'b0, FA},     8'h20, 8'h10, 1'b0, 8'h00, 8'h11, 1'b0},
      '{{OPG_BYTE, SUB_ORF, 1'b0, FA},       8'h91, 8'h13, 1'b0, 8'h00, 8'h93, 1'b0},
      '{{OPG_BYTE, SUB_ORF, 1'b1, FA},       8'h00, 8'h00, 1'b1, 8'h00, 8'h00, 1'b1},
      '{{OPG_BYTE, SUB_MOVEF, 1'b0, FA},     8'h55, 8'h00, 1'b0, 8'h00, 8'h00, 1'b1},
      '{{OPG_BYTE, SUB_MOVEF, 1'b1, FA},     8'h00, 8'h3C, 1'b1, 8'h3C, 8'h00, 1'b0},
      '{{OPG_BYTE, SUB_WTOF, 1'b1, FA},      8'h4F, 8'hFF, 1'b1, 8'h4F, 8'h4F, 1'b0},
      '{{OPG_LIT, SUB_ORLIT, 8'h35},         8'h9A, 8'h00, 1'b0, 8'h00, 8'hBF, 1'b0},
      '{{OPG_LIT, LSUB_LDLIT, 2'b00, 8'h5A}, 8'h00, 8'h00, 1'b0, 8'h00, 8'h5A, 1'b1},
      '{{OPG_BIT, BSUB_SET, 3'd0, FA},       8'h77, 8'hFE, 1'b1, 8'hFF, 8'h77, 1'b0}
    };
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    chk(32'({working_reg, zero_flag, file_wr}), 32'h0000_0000);
    chk(32'(pc_ctrl), 32'h0000_0000);
    reg_read(OFS_STATUS);
    chk(rd, 32'h0000_0600);
    @(posedge core_clk);
    #1;
    chk(reg_rdata, 32'h0000_0000);
    reg_read(8'h40);
    chk(rd, 32'h0000_0000);
    $display("test reset done");

    for (int i = 0; i < 19; i++) begin
      preset_w(rows[i].wpre);
      fmem[FA] = rows[i].fval;
      exec(rows[i].word);
      chk(32'({file_wr.we, file_wr.we ? {file_wr.addr, file_wr.data} : 15'h0000}),
          32'({rows[i].we, rows[i].we ? {FA, rows[i].fdata} : 15'h0000}));
      chk(32'({working_reg, zero_flag}), 32'({rows[i].w, rows[i].z}));
    end
    $display("test table done");

    skip_case({OPG_BIT, BSUB_TSTSET, 3'd3, FA}, 8'h08, 1'b1, 9'h000);
    skip_case({OPG_BIT, BSUB_TSTSET, 3'd3, FA}, 8'hF7, 1'b0, 9'h000);
    skip_case({OPG_BYTE, SUB_DECSZ, 1'b1, FA}, 8'h01, 1'b1, 9'h100);
    skip_case({OPG_BYTE, SUB_DECSZ, 1'b0, FA}, 8'h03, 1'b0, 9'h000);
    skip_case({OPG_BYTE, SUB_INCSZ, 1'b1, FA}, 8'hFF, 1'b1, 9'h100);
    skip_case({OPG_BYTE, SUB_INCSZ, 1'b0, FA}, 8'h00, 1'b0, 9'h000);
    $display("test skips done");

    reg_write(OFS_LATCH, 32'h0000_0008);
    skip_case({OPG_CTRL, 1'b0, 11'h5A5}, 8'h00, 1'b1, 9'h000);
    chk(32'(snap_pcc), 32'({2'b11, 13'h0DA5, 13'h0124}));
    reg_write(OFS_LATCH, 32'h0000_0010);
    reg_read(OFS_LATCH);
    chk(rd, 32'h0000_0010);
    skip_case({OPG_CTRL, 1'b1, 11'h2F0}, 8'h00, 1'b1, 9'h000);
    chk(32'({snap_pcc.load, snap_pcc.push, snap_pcc.target}), 32'({2'b10, 13'h12F0}));
    $display("test call and branch done");

    reg_write(OFS_CTRL, 32'h0000_0000);
    exec({OPG_LIT, LSUB_LDLIT, 2'b00, 8'h66});
    chk(32'({working_reg, file_wr.we, pc_ctrl.load}), 32'h0000_0044);
    reg_write(OFS_CTRL, 32'h0000_0001);
    reg_read(OFS_CTRL);
    chk(rd, 32'h0000_0001);
    exec({OPG_LIT, LSUB_LDLIT, 2'b00, 8'h66});
    chk(32'(working_reg), 32'h0000_0066);
    $display("test execute enable done");

    reg_write(OFS_STATUS, 32'h0000_0000);
    reg_read(OFS_STATUS);
    chk(32'(rd[10:9]), 32'h0000_0000);
    // Let the prescaler and counter run away from zero first
    repeat (300) @(posedge core_clk);
    exec(WDOG_CLR_WORD);
    reg_read(OFS_STATUS);
    chk(32'(rd[10:9]), 32'h0000_0003);
    reg_read(OFS_WDOG);
    chk(32'({rd[15:11], rd[7:0]}), 32'h0000_0000);
    $display("test watchdog clear done");
    complete_run();
  end

endmodule // testbench
